/* bench/nvm_prog_asserts.sv */
`timescale 1ns/1ps
module nvm_prog_asserts #(
	parameter int unsigned WRITE_CYCLES = 20,
	parameter logic [23:0] SIGNATURE = 24'h00_0000,
	parameter logic [7:0] CALIBRATION = 8'h00
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] data_dev,
	input wire logic data_dev_oe,
	input wire logic [7:0] data_bus,
	input wire logic [1:0] load_sel,
	input wire logic load_strobe,
	input wire logic rd_oe_n,
	input wire logic byte_select_one,
	input wire logic reset_n,
	input wire logic sck,
	input wire logic write_busy_o,
	input wire logic write_done_o,
	input wire logic prog_enabled_o,
	input wire logic refused_o
);
	// ****************************************
	// Shadow of loaded command, address and write length
	// ****************************************
	logic [7:0] cmd_ff, nxt_cmd, addr_ff, nxt_addr; // Last loads seen on the wire
	logic [31:0] busy_ff, nxt_busy; // Busy cycles so far
	logic [31:0] sig_ext; // Signature with FF above the last byte
	logic [7:0] sig_byte; // Byte the device owes for addr_ff
	// Next values; loads while reading are ignored, as on the device
	always_comb
	begin
		nxt_cmd = cmd_ff;
		nxt_addr = addr_ff;
		if (load_strobe && rd_oe_n && load_sel == nvm_prog_pkg::SEL_CMD)
			nxt_cmd = data_bus;
		if (load_strobe && rd_oe_n && load_sel == nvm_prog_pkg::SEL_ADDR)
			nxt_addr = data_bus;
		nxt_busy = write_busy_o ? busy_ff + 32'h0000_0001 : 32'h0000_0000;
		sig_ext = {8'hff, SIGNATURE};
		sig_byte = (addr_ff > nvm_prog_pkg::ADDR_SIG_LAST) ? 8'hff : sig_ext[{addr_ff[1:0], 3'h0} +: 8];
	end
	// Registers only
	always_ff @(posedge clk_i)
	begin
		cmd_ff <= rst_i ? 8'h00 : nxt_cmd;
		addr_ff <= rst_i ? 8'h00 : nxt_addr;
		busy_ff <= rst_i ? 32'h0000_0000 : nxt_busy;
	end
	// ****************************************
	// Properties
	// ****************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_cmd_load;
		load_strobe && load_sel == nvm_prog_pkg::SEL_CMD && data_bus == nvm_prog_pkg::CMD_READ_IDENT;
	endsequence
	sequence s_addr_load;
		load_strobe && load_sel == nvm_prog_pkg::SEL_ADDR;
	endsequence
	// Read enable held low for two samples with a steady byte select
	sequence s_read_held;
		!rd_oe_n && !$past(rd_oe_n) && $stable(byte_select_one) && cmd_ff == nvm_prog_pkg::CMD_READ_IDENT;
	endsequence
	property p_load_order;
		load_strobe && load_sel == nvm_prog_pkg::SEL_CMD |-> s_cmd_load ##1 s_addr_load ##1 !rd_oe_n;
	endproperty
	a_load_order: assert property (p_load_order) else $error("load order wrong");
	property p_sig_out;
		s_read_held ##0 !byte_select_one |-> data_dev_oe && data_dev == sig_byte;
	endproperty
	a_sig_out: assert property (p_sig_out) else $error("signature byte wrong");
	property p_calib_out;
		s_read_held ##0 byte_select_one |-> data_dev_oe && data_dev == CALIBRATION;
	endproperty
	a_calib_out: assert property (p_calib_out) else $error("calibration byte wrong");
	property p_release;
		rd_oe_n && $past(rd_oe_n) |-> !data_dev_oe;
	endproperty
	a_release: assert property (p_release) else $error("data bus not released");
	property p_enable_clear;
		reset_n [*3] |-> !prog_enabled_o;
	endproperty
	a_enable_clear: assert property (p_enable_clear) else $error("enable kept with pin high");
	property p_refuse;
		refused_o |-> !prog_enabled_o ##1 !$rose(write_busy_o);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refusal while enabled");
	property p_write_len;
		$fell(write_busy_o) && !$past(rst_i) |-> busy_ff == WRITE_CYCLES;
	endproperty
	a_write_len: assert property (p_write_len) else $error("write length wrong");
	property p_done;
		write_done_o |-> $past(write_busy_o);
	endproperty
	a_done: assert property (p_done) else $error("done without write");
	property p_write_runs;
		write_busy_o && busy_ff < WRITE_CYCLES - 1 |=> write_busy_o;
	endproperty
	a_write_runs: assert property (p_write_runs) else $error("write cut short");
	property p_sck_idle;
		reset_n |-> !sck;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("serial clock moves with pin high");
endmodule

/* bench/nvm_programming_identity_read_test.sv */
`timescale 1ns/1ps
module nvm_programming_identity_read_test;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int unsigned WCYC = 20; // Short write keeps the run brief
	logic clk_i, rst_i, write_req_i, write_busy_o, write_done_o, prog_enabled_o, refused_o;
	logic rd_req_i, rd_calib_i, rd_valid_o, ser_req_i, prog_mode_i, ser_done_o, busy_o;
	logic [7:0] rd_addr_i, rd_data_o, ser_resp_o;
	logic [31:0] ser_word_i;
	logic [23:0] sig; // Expected signature bytes
	int err_count, n_checks, n_ref, n_done, n_busy; // Counters, events seen
	nvm_prog_if pins();
	nvm_prog_device #(.WRITE_CYCLES(WCYC)) u_nvm_prog_device (.clk_i(clk_i), .rst_i(rst_i), .pins(pins),
		.write_req_i(write_req_i), .write_busy_o(write_busy_o), .write_done_o(write_done_o),
		.prog_enabled_o(prog_enabled_o), .refused_o(refused_o));
	nvm_prog_host u_nvm_prog_host (.clk_i(clk_i), .rst_i(rst_i), .pins(pins), .rd_req_i(rd_req_i),
		.rd_calib_i(rd_calib_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.ser_req_i(ser_req_i), .ser_word_i(ser_word_i), .prog_mode_i(prog_mode_i), .ser_resp_o(ser_resp_o),
		.ser_done_o(ser_done_o), .busy_o(busy_o));
	nvm_prog_asserts #(.WRITE_CYCLES(WCYC), .SIGNATURE(nvm_prog_pkg::SIG_DEFAULT),
		.CALIBRATION(nvm_prog_pkg::CALIB_DEFAULT)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
		.data_dev(pins.data_dev), .data_dev_oe(pins.data_dev_oe), .data_bus(pins.data_bus),
		.load_sel(pins.load_sel), .load_strobe(pins.load_strobe), .rd_oe_n(pins.rd_oe_n),
		.byte_select_one(pins.byte_select_one), .reset_n(pins.reset_n), .sck(pins.sck),
		.write_busy_o(write_busy_o), .write_done_o(write_done_o), .prog_enabled_o(prog_enabled_o),
		.refused_o(refused_o));
	// Free-running clock
	initial
	begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	// Event tally; values seen at the edge are the settled pre-edge ones
	always @(posedge clk_i)
	begin
		n_ref += (refused_o === 1'b1);
		n_done += (write_done_o === 1'b1);
		n_busy += (write_busy_o === 1'b1);
	end
	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One parallel read; waits out the bus release before returning
	task automatic par_read(input logic calib, input logic [7:0] addr, input logic [7:0] exp);
		int k;
		@(posedge clk_i);
		rd_req_i <= 1'b1;
		rd_calib_i <= calib;
		rd_addr_i <= addr;
		@(posedge clk_i);
		rd_req_i <= 1'b0;
		for (k = 0; k < 20 && rd_valid_o !== 1'b1; k++)
			@(posedge clk_i);
		check("read valid", {31'h0000_0000, rd_valid_o}, 32'h0000_0001);
		check("read byte", {24'h00_0000, rd_data_o}, {24'h00_0000, exp});
		repeat (3) @(posedge clk_i);
		check("device drive", {31'h0000_0000, pins.data_dev_oe}, 32'h0000_0000);
		check("host idle", {31'h0000_0000, busy_o}, 32'h0000_0000);
	endtask
	// One serial instruction; done tells whether it completed
	task automatic ser_send(input logic [31:0] word, output logic done);
		int k;
		@(posedge clk_i);
		ser_req_i <= 1'b1;
		ser_word_i <= word;
		@(posedge clk_i);
		ser_req_i <= 1'b0;
		for (k = 0; k < 400 && ser_done_o !== 1'b1; k++)
			@(posedge clk_i);
		done = ser_done_o;
	endtask
	// Bounded wait for the end of a write
	task automatic wait_done(input int d0);
		for (int k = 0; k < 100 && n_done == d0; k++)
			@(posedge clk_i);
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_identity;
		sig = nvm_prog_pkg::SIG_DEFAULT;
		for (int a = 0; a < 3; a++)
			par_read(1'b0, a[7:0], sig[8*a +: 8]);
		par_read(1'b0, 8'h03, 8'hff);
		par_read(1'b1, nvm_prog_pkg::ADDR_CALIB, nvm_prog_pkg::CALIB_DEFAULT);
		$display("Test identity done");
	endtask
	// Serial traffic is ignored with the pin high; writes refused before enable
	task automatic t_gate;
		logic done;
		int r0, b0;
		ser_send({nvm_prog_pkg::SER_PROG_ENABLE, 24'h00_0000}, done);
		check("ignored instr", {31'h0000_0000, done}, 32'h0000_0000);
		prog_mode_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		r0 = n_ref;
		b0 = n_busy;
		ser_send({nvm_prog_pkg::SER_WRITE_OP, 24'h00_0000}, done);
		repeat (2) @(posedge clk_i);
		check("refusals", n_ref - r0, 32'h0000_0001);
		check("busy cycles", n_busy - b0, 32'h0000_0000);
		$display("Test gate done");
	endtask
	// Enable, write, release the pin mid-write, then re-entry needs enable again
	task automatic t_enable_write;
		logic done;
		int d0, b0, r0;
		ser_send({nvm_prog_pkg::SER_PROG_ENABLE, 24'h00_0000}, done);
		@(posedge clk_i);
		check("instr done", {31'h0000_0000, done}, 32'h0000_0001);
		check("echo", {24'h00_0000, ser_resp_o}, {24'h00_0000, nvm_prog_pkg::SER_ENABLE_ECHO});
		check("enabled", {31'h0000_0000, prog_enabled_o}, 32'h0000_0001);
		d0 = n_done;
		b0 = n_busy;
		ser_send({nvm_prog_pkg::SER_WRITE_OP, 24'h00_0000}, done);
		repeat (2) @(posedge clk_i);
		prog_mode_i <= 1'b0;
		wait_done(d0);
		check("write cycles", n_busy - b0, WCYC);
		check("enable cleared", {31'h0000_0000, prog_enabled_o}, 32'h0000_0000);
		prog_mode_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		r0 = n_ref;
		ser_send({nvm_prog_pkg::SER_WRITE_OP, 24'h00_0000}, done);
		repeat (2) @(posedge clk_i);
		check("refused again", n_ref - r0, 32'h0000_0001);
		prog_mode_i <= 1'b0;
		$display("Test enable write done");
	endtask
	// Self-timed write from the request input
	task automatic t_self_write;
		int d0, b0;
		d0 = n_done;
		b0 = n_busy;
		@(posedge clk_i);
		write_req_i <= 1'b1;
		@(posedge clk_i);
		write_req_i <= 1'b0;
		wait_done(d0);
		@(posedge clk_i);
		check("self write cycles", n_busy - b0, WCYC);
		check("done pulses", n_done - d0, 32'h0000_0001);
		$display("Test self write done");
	endtask
	// ****************************************
	// Run control
	// ****************************************
	task automatic conclude;
		$display("Checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Watchdog: the whole sequence needs about 1050 cycles
	initial
	begin
		#40000;
		err_count++;
		conclude();
	end
	initial
	begin
		{rst_i, write_req_i, rd_req_i, rd_calib_i, ser_req_i, prog_mode_i} = 6'h20;
		{rd_addr_i, ser_word_i} = 40'h00_0000_0000;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		t_identity();
		t_gate();
		t_enable_write();
		t_self_write();
		conclude();
	end
endmodule

/* design/nvm_prog_device.sv */
`timescale 1ns/1ps
module nvm_prog_device #(
	parameter int unsigned WRITE_CYCLES = nvm_prog_pkg::WRITE_CYC,
	parameter logic [23:0] SIGNATURE = nvm_prog_pkg::SIG_DEFAULT,
	parameter logic [7:0] CALIBRATION = nvm_prog_pkg::CALIB_DEFAULT
)
(
	input wire logic clk_i,
	input wire logic rst_i,
	nvm_prog_if.device pins,
	input wire logic write_req_i,      // Self-programmed write request pulse
	output logic write_busy_o,         // Write in progress
	output logic write_done_o,         // One-cycle pulse at write end
	output logic prog_enabled_o,       // Serial programming enabled
	output logic refused_o             // One-cycle pulse on refused write op
);

	// Refuse a zero-length write at elaboration; the timer compares against WRITE_CYCLES - 1
	if (WRITE_CYCLES < 1)
	begin : g_write_cycles_check
		$error("WRITE_CYCLES must be at least one");
	end

	// ****************************************
	// Parallel read path
	// ****************************************
	logic [7:0] cmd_ff, nxt_cmd;            // Loaded command
	logic [7:0] addr_ff, nxt_addr;          // Loaded address low byte
	logic [7:0] dout_ff, nxt_dout;          // Driven data
	logic doe_ff, nxt_doe;                  // Drive enable

	// Load latches and output selection
	always_comb
	begin
		nxt_cmd = cmd_ff;
		nxt_addr = addr_ff;
		nxt_dout = dout_ff;
		nxt_doe = 1'b0;                       // Released unless read active
		if (pins.load_strobe && pins.rd_oe_n)
		begin
			if (pins.load_sel == nvm_prog_pkg::SEL_CMD)
				nxt_cmd = pins.data_bus;
			else if (pins.load_sel == nvm_prog_pkg::SEL_ADDR)
				nxt_addr = pins.data_bus;
		end
		if (!pins.rd_oe_n && cmd_ff == nvm_prog_pkg::CMD_READ_IDENT)
		begin
			nxt_doe = 1'b1;
			if (pins.byte_select_one)
				nxt_dout = CALIBRATION;
			else if (addr_ff <= nvm_prog_pkg::ADDR_SIG_LAST)
				nxt_dout = SIGNATURE[8 * addr_ff[1:0] +: 8];
			else
				nxt_dout = 8'hff;                 // Unmapped signature address
		end
	end

	// Register the read path
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cmd_ff <= 8'h00;
			addr_ff <= 8'h00;
			dout_ff <= 8'h00;
			doe_ff <= 1'b0;
		end
		else
		begin
			cmd_ff <= nxt_cmd;
			addr_ff <= nxt_addr;
			dout_ff <= nxt_dout;
			doe_ff <= nxt_doe;
		end
	end

	assign pins.data_dev = dout_ff;
	assign pins.data_dev_oe = doe_ff;

	// ****************************************
	// Serial download engine
	// ****************************************
	logic sck_d_ff, nxt_sck_d;              // Previous SCK for edge find
	logic [2:0] bit_ff, nxt_bit;            // Bit within byte
	logic [1:0] byte_ff, nxt_byte;          // Byte within instruction
	logic [7:0] shin_ff, nxt_shin;          // Receive shift
	logic [7:0] first_ff, nxt_first;        // First byte of instruction
	logic [7:0] shout_ff, nxt_shout;        // Transmit shift
	logic en_ff, nxt_en;                    // Programming enabled
	logic refused_ff, nxt_refused;
	logic ser_wreq;                         // Serial write launch

	// Shift in on rising SCK, shift out on falling SCK
	always_comb
	begin
		nxt_sck_d = pins.sck;
		nxt_bit = bit_ff;
		nxt_byte = byte_ff;
		nxt_shin = shin_ff;
		nxt_first = first_ff;
		nxt_shout = shout_ff;
		nxt_en = en_ff;
		nxt_refused = 1'b0;
		ser_wreq = 1'b0;
		if (pins.reset_n)
		begin
			// Link idle while reset pin high; enable lost
			nxt_bit = 3'h0;
			nxt_byte = 2'h0;
			nxt_en = 1'b0;
			nxt_shout = 8'h00;
		end
		else if (pins.sck && !sck_d_ff)
		begin
			nxt_shin = {shin_ff[6:0], pins.mosi};
			nxt_bit = bit_ff + 3'h1;
			if (bit_ff == 3'h7)
			begin
				nxt_byte = byte_ff + 2'h1;
				if (byte_ff == 2'h0)
					nxt_first = nxt_shin;
				// Echo on third byte when enable is seen
				nxt_shout = (byte_ff == 2'h1 && first_ff == nvm_prog_pkg::SER_PROG_ENABLE)
					? nvm_prog_pkg::SER_ENABLE_ECHO : 8'h00;
				if (byte_ff == 2'(nvm_prog_pkg::SER_BYTES - 1))
				begin
					if (first_ff == nvm_prog_pkg::SER_PROG_ENABLE)
						nxt_en = 1'b1;
					else if (first_ff == nvm_prog_pkg::SER_WRITE_OP)
					begin
						if (en_ff)
							ser_wreq = 1'b1;
						else
							nxt_refused = 1'b1;
					end
				end
			end
		end
		else if (!pins.sck && sck_d_ff && bit_ff != 3'h0)
			nxt_shout = {shout_ff[6:0], 1'b0};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sck_d_ff <= 1'b0;
			bit_ff <= 3'h0;
			byte_ff <= 2'h0;
			shin_ff <= 8'h00;
			first_ff <= 8'h00;
			shout_ff <= 8'h00;
			en_ff <= 1'b0;
			refused_ff <= 1'b0;
		end
		else
		begin
			sck_d_ff <= nxt_sck_d;
			bit_ff <= nxt_bit;
			byte_ff <= nxt_byte;
			shin_ff <= nxt_shin;
			first_ff <= nxt_first;
			shout_ff <= nxt_shout;
			en_ff <= nxt_en;
			refused_ff <= nxt_refused;
		end
	end

	assign pins.miso = shout_ff[7];
	assign prog_enabled_o = en_ff;
	assign refused_o = refused_ff;

	// ****************************************
	// Write timer
	// ****************************************
	// Only power-on rst_i stops a write; the reset pin never does, so an
	// interrupted download still leaves a complete write behind.
	logic busy_ff, nxt_busy;
	logic done_ff, nxt_done;
	logic [31:0] wcnt_ff, nxt_wcnt;

	always_comb
	begin
		nxt_busy = busy_ff;
		nxt_done = 1'b0;
		nxt_wcnt = wcnt_ff;
		if (busy_ff)
		begin
			// Run to the end regardless of reset pin
			if (wcnt_ff == 32'(WRITE_CYCLES - 1))
			begin
				nxt_busy = 1'b0;
				nxt_done = 1'b1;
			end
			else
				nxt_wcnt = wcnt_ff + 32'h0000_0001;
		end
		else if (write_req_i || ser_wreq)
		begin
			nxt_busy = 1'b1;
			nxt_wcnt = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			wcnt_ff <= 32'h0000_0000;
		end
		else
		begin
			busy_ff <= nxt_busy;
			done_ff <= nxt_done;
			wcnt_ff <= nxt_wcnt;
		end
	end

	assign write_busy_o = busy_ff;
	assign write_done_o = done_ff;

endmodule

/* design/nvm_prog_host.sv */
`timescale 1ns/1ps
// Programmer end: sequences parallel identity reads and serial instructions
module nvm_prog_host
(
	input wire logic clk_i,
	input wire logic rst_i,
	nvm_prog_if.host pins,
	input wire logic rd_req_i,          // Start a parallel read
	input wire logic rd_calib_i,        // High: calibration, low: signature
	input wire logic [7:0] rd_addr_i,   // Signature address 00-02
	output logic [7:0] rd_data_o,       // Captured byte
	output logic rd_valid_o,            // One-cycle pulse with data
	input wire logic ser_req_i,         // Send one serial instruction
	input wire logic [31:0] ser_word_i, // Instruction, first byte in top bits
	input wire logic prog_mode_i,       // Hold reset pin low for download
	output logic [7:0] ser_resp_o,      // Third byte returned by device
	output logic ser_done_o,            // One-cycle pulse at end
	output logic busy_o
);

	// ****************************************
	// Parallel read sequencer
	// ****************************************
	typedef enum {P_IDLE, P_CMD, P_ADDR, P_OE, P_WAIT, P_CAP, P_REL} pstate_t;
	pstate_t ps_ff, nxt_ps;
	logic [7:0] dh_ff, nxt_dh;
	logic dhoe_ff, nxt_dhoe, strb_ff, nxt_strb, oen_ff, nxt_oen, bs_ff, nxt_bs;
	logic [1:0] sel_ff, nxt_sel;
	logic [7:0] rdat_ff, nxt_rdat, raddr_ff, nxt_raddr;
	logic rval_ff, nxt_rval, rcal_ff, nxt_rcal;

	always_comb
	begin
		nxt_ps = ps_ff;
		nxt_dh = dh_ff;
		nxt_dhoe = 1'b0;
		nxt_strb = 1'b0;
		nxt_oen = oen_ff;
		nxt_bs = bs_ff;
		nxt_sel = sel_ff;
		nxt_rdat = rdat_ff;
		nxt_raddr = raddr_ff;
		nxt_rcal = rcal_ff;
		nxt_rval = 1'b0;
		unique case (ps_ff)
			P_IDLE:
				if (rd_req_i)
				begin
					nxt_raddr = rd_calib_i ? nvm_prog_pkg::ADDR_CALIB : rd_addr_i;
					nxt_rcal = rd_calib_i;
					nxt_dh = nvm_prog_pkg::CMD_READ_IDENT;
					nxt_sel = nvm_prog_pkg::SEL_CMD;
					nxt_dhoe = 1'b1;
					nxt_strb = 1'b1;
					nxt_ps = P_CMD;
				end
			P_CMD:
			begin
				nxt_dh = raddr_ff;
				nxt_sel = nvm_prog_pkg::SEL_ADDR;
				nxt_dhoe = 1'b1;
				nxt_strb = 1'b1;
				nxt_ps = P_ADDR;
			end
			P_ADDR:
			begin
				nxt_bs = rcal_ff;
				nxt_oen = 1'b0;
				nxt_ps = P_OE;
			end
			P_OE:
				nxt_ps = P_WAIT;
			P_WAIT:
				nxt_ps = P_CAP;
			P_CAP:
			begin
				nxt_rdat = pins.data_bus;
				nxt_rval = 1'b1;
				nxt_oen = 1'b1;
				nxt_ps = P_REL;
			end
			P_REL:
				if (!pins.data_dev_oe)
					nxt_ps = P_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ps_ff <= P_IDLE;
			dh_ff <= 8'h00;
			dhoe_ff <= 1'b0;
			strb_ff <= 1'b0;
			oen_ff <= 1'b1;
			bs_ff <= 1'b0;
			sel_ff <= 2'h0;
			rdat_ff <= 8'h00;
			raddr_ff <= 8'h00;
			rcal_ff <= 1'b0;
			rval_ff <= 1'b0;
		end
		else
		begin
			ps_ff <= nxt_ps;
			dh_ff <= nxt_dh;
			dhoe_ff <= nxt_dhoe;
			strb_ff <= nxt_strb;
			oen_ff <= nxt_oen;
			bs_ff <= nxt_bs;
			sel_ff <= nxt_sel;
			rdat_ff <= nxt_rdat;
			raddr_ff <= nxt_raddr;
			rcal_ff <= nxt_rcal;
			rval_ff <= nxt_rval;
		end
	end

	assign pins.data_host = dh_ff;
	assign pins.data_host_oe = dhoe_ff;
	assign pins.load_strobe = strb_ff;
	assign pins.load_sel = sel_ff;
	assign pins.rd_oe_n = oen_ff;
	assign pins.byte_select_one = bs_ff;
	assign rd_data_o = rdat_ff;
	assign rd_valid_o = rval_ff;

	// ****************************************
	// Serial instruction shifter
	// ****************************************
	// SCK half period of two clocks keeps well inside device sampling.
	logic rstn_ff, nxt_rstn, sck_ff, nxt_sck, mosi_ff, nxt_mosi, sdone_ff, nxt_sdone, sact_ff, nxt_sact;
	logic [31:0] sh_ff, nxt_sh;
	logic [5:0] cnt_ff, nxt_cnt;
	logic ph_ff, nxt_ph;
	logic [7:0] resp_ff, nxt_resp;

	always_comb
	begin
		nxt_rstn = !prog_mode_i;
		nxt_sck = sck_ff;
		nxt_mosi = mosi_ff;
		nxt_sh = sh_ff;
		nxt_cnt = cnt_ff;
		nxt_ph = ~ph_ff;
		nxt_resp = resp_ff;
		nxt_sdone = 1'b0;
		nxt_sact = sact_ff;
		if (!sact_ff)
		begin
			nxt_ph = 1'b0;
			if (ser_req_i && !rstn_ff)
			begin
				nxt_sact = 1'b1;
				nxt_sh = ser_word_i;
				nxt_mosi = ser_word_i[31];
				nxt_cnt = 6'h00;
			end
		end
		else if (ph_ff)
		begin
			nxt_sck = ~sck_ff;
			if (!sck_ff)
			begin
				if (cnt_ff[4:3] == 2'h2)
					nxt_resp = {resp_ff[6:0], pins.miso};
			end
			else
			begin
				nxt_sh = {sh_ff[30:0], 1'b0};
				nxt_mosi = sh_ff[30];
				nxt_cnt = cnt_ff + 6'h01;
				if (cnt_ff == 6'h1f)
				begin
					nxt_sact = 1'b0;
					nxt_sdone = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rstn_ff <= 1'b1;
			sck_ff <= 1'b0;
			mosi_ff <= 1'b0;
			sh_ff <= 32'h0000_0000;
			cnt_ff <= 6'h00;
			ph_ff <= 1'b0;
			resp_ff <= 8'h00;
			sdone_ff <= 1'b0;
			sact_ff <= 1'b0;
		end
		else
		begin
			rstn_ff <= nxt_rstn;
			sck_ff <= nxt_sck;
			mosi_ff <= nxt_mosi;
			sh_ff <= nxt_sh;
			cnt_ff <= nxt_cnt;
			ph_ff <= nxt_ph;
			resp_ff <= nxt_resp;
			sdone_ff <= nxt_sdone;
			sact_ff <= nxt_sact;
		end
	end

	assign pins.reset_n = rstn_ff;
	assign pins.sck = sck_ff;
	assign pins.mosi = mosi_ff;
	assign ser_resp_o = resp_ff;
	assign ser_done_o = sdone_ff;
	assign busy_o = sact_ff || (ps_ff != P_IDLE);

endmodule

/* design/nvm_prog_if.sv */
`timescale 1ns/1ps
interface nvm_prog_if;

	// Parallel programming pins
	logic [7:0] data_dev;       // Data driven by device
	logic data_dev_oe;          // Device drives data bus
	logic [7:0] data_host;      // Data driven by programmer
	logic data_host_oe;         // Programmer drives data bus
	logic [7:0] data_bus;       // Resolved bus level
	logic [1:0] load_sel;       // Command or address select
	logic load_strobe;          // One-cycle load strobe
	logic rd_oe_n;              // Read output enable, active low
	logic byte_select_one;      // Byte select one
	// Serial link and reset pin
	logic reset_n;              // Device reset pin, active low
	logic sck;
	logic mosi;
	logic miso;

	// Resolve the shared data wire; programmer wins only if device is silent
	assign data_bus = data_dev_oe ? data_dev : (data_host_oe ? data_host : 8'h00);

	modport device
	(
		input data_bus, load_sel, load_strobe, rd_oe_n, byte_select_one, reset_n, sck, mosi,
		output data_dev, data_dev_oe, miso
	);

	modport host
	(
		input data_bus, data_dev_oe, miso,
		output data_host, data_host_oe, load_sel, load_strobe, rd_oe_n, byte_select_one, reset_n, sck, mosi
	);

endinterface

/* design/nvm_prog_pkg.sv */
package nvm_prog_pkg;

	// ****************************************
	// Parallel command and address codes
	// ****************************************
	localparam logic [7:0] CMD_READ_IDENT = 8'h08;   // Command pattern 0000 1000
	localparam logic [7:0] ADDR_SIG_LAST = 8'h02;    // Highest signature address
	localparam logic [7:0] ADDR_CALIB = 8'h00;       // Calibration byte address
	localparam logic [1:0] SEL_CMD = 2'h1;           // Load selector: command
	localparam logic [1:0] SEL_ADDR = 2'h0;          // Load selector: address low

	// ****************************************
	// Serial instruction codes
	// ****************************************
	localparam logic [7:0] SER_PROG_ENABLE = 8'hac;  // First byte of enable instruction
	localparam logic [7:0] SER_ENABLE_ECHO = 8'h53;  // Echo byte after acceptance
	localparam logic [7:0] SER_WRITE_OP = 8'h4c;     // First byte of a write/erase op
	localparam int unsigned SER_BYTES = 4;           // Bytes per instruction

	// ****************************************
	// Write timing
	// ****************************************
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned WRITE_MIN_US = 3200;     // 3.2 ms
	localparam int unsigned WRITE_MAX_US = 3400;     // 3.4 ms
	localparam int unsigned WRITE_MIN_CYC = WRITE_MIN_US * CLK_MHZ;
	localparam int unsigned WRITE_MAX_CYC = WRITE_MAX_US * CLK_MHZ;
	// Target the middle of the window
	localparam int unsigned WRITE_CYC = (WRITE_MIN_CYC + WRITE_MAX_CYC) / 2;

	// ****************************************
	// Default identity and calibration bytes (arbitrary values)
	// ****************************************
	localparam logic [23:0] SIG_DEFAULT = 24'h12_3456;
	localparam logic [7:0] CALIB_DEFAULT = 8'h80;

endpackage
